// ==== jtag_ice_pkg.sv ====
// Behaviour
// - Selection sampled low routes the test port to the emulator debug logic.
// - Selection sampled high makes the test port a standard boundary-scan port.
// - A new selection takes effect only after a full chip reset.
// - Boundary-scan mode implements the SAMPLE, EXTEST and BYPASS instructions.
// - Emulator mode identification returns a processor-specific, non-standard identifier.
// - Pin scan chain is exactly 484 bits long.
// - Each bidirectional pin has an output, an input and a control cell.
// - During external test the output cell value drives the pad.
// - Input cell captures the level present on the pad.
// - Control cell decides whether the pad is driven during external test.
// - Emulator mode shifts instructions and data serially without the system bus.
// - Two internal processor scan chains are controlled through the test port.
// - Debug channel transmit and receive activity become interrupt requests.
// - A block input prevents system access through the emulator interface.
// - A readable 32-bit chip identification register reports version and configuration.
package jtag_ice_pkg;

    // Pin scan chain layout
    localparam int CHAIN_BITS = 484;
    localparam int N_BIDIR    = 161;
    localparam int N_INPUT    = 1;
    localparam int INPUT_CELL = 0;
    localparam int BIDIR_BASE = N_INPUT;
    localparam int CELL_IN    = 0;
    localparam int CELL_OUT   = 1;
    localparam int CELL_CTL   = 2;
    localparam int CELLS_PIN  = 3;

    // Instruction register
    localparam int          IR_LEN     = 4;
    localparam logic [3:0]  OP_EXTEST  = 4'h0;
    localparam logic [3:0]  OP_SAMPLE  = 4'h1;
    localparam logic [3:0]  OP_SCAN_N  = 4'h2;
    localparam logic [3:0]  OP_INTEST  = 4'hc;
    localparam logic [3:0]  OP_IDCODE  = 4'he;
    localparam logic [3:0]  OP_BYPASS  = 4'hf;
    localparam logic [3:0]  IR_CAPTURE = 4'h1;

    // Chain select register
    localparam int          SCAN_N_LEN = 4;
    localparam logic [3:0]  CHAIN_A    = 4'h1;
    localparam logic [3:0]  CHAIN_B    = 4'h2;
    localparam logic [3:0]  SCAN_N_RST = 4'h0;

    // Identification values, arbitrary
    localparam int          ID_LEN        = 32;
    localparam logic [31:0] EMU_ID_VALUE  = 32'h0a5a_0001;
    localparam logic [31:0] CHIP_ID_VALUE = 32'h0c0d_e001;

    // Timing
    localparam int CORE_CLK_NS = 25;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [2:0] {DR_BYPASS, DR_PINS, DR_ID, DR_SCANN, DR_CHAIN} dr_sel_t;

    // Strobes to the processor's internal scan chains
    typedef struct packed {
        logic [1:0] select;
        logic       capture;
        logic       shift;
        logic       update;
    } emu_chain_ctl_t;

endpackage

// ==== pin_scan_chain.sv ====
`timescale 1ns/1ps
module pin_scan_chain import jtag_ice_pkg::*; (
    // Link clock
    input  wire logic               tck,
    input  wire logic               test_port_reset_n,
    // Chain control from the test port
    input  wire logic               capture,
    input  wire logic               shift,
    input  wire logic               update,
    input  wire logic               tdi,
    output logic                    chain_tdo,
    // Levels captured into the cells
    input  wire logic [N_BIDIR-1:0] pad_in,
    input  wire logic [N_BIDIR-1:0] core_pad_out,
    input  wire logic [N_BIDIR-1:0] core_pad_oe,
    input  wire logic               boot_mode_pin,
    // Update stage per pin
    output logic [N_BIDIR-1:0]      upd_out,
    output logic [N_BIDIR-1:0]      upd_ctl
);

    logic [CHAIN_BITS-1:0] shift_reg;
    logic [CHAIN_BITS-1:0] update_reg;
    logic [CHAIN_BITS-1:0] cap_vec;
    logic [N_BIDIR-1:0]    in_meta, in_sync, out_meta, out_sync, oe_meta, oe_sync;
    logic                  bm_meta, bm_sync;

    // Pads and core levels are foreign to the link clock, so resync first
    always_ff @(posedge tck) begin
        in_meta  <= pad_in;
        in_sync  <= in_meta;
        out_meta <= core_pad_out;
        out_sync <= out_meta;
        oe_meta  <= core_pad_oe;
        oe_sync  <= oe_meta;
        bm_meta  <= boot_mode_pin;
        bm_sync  <= bm_meta;
    end

    // Cell placement: input-only cell first, then three cells per bidirectional pin
    assign cap_vec[INPUT_CELL] = bm_sync;
    for (genvar k = 0; k < N_BIDIR; k++) begin : g_pin
        assign cap_vec[BIDIR_BASE + CELLS_PIN*k + CELL_IN]  = in_sync[k];
        assign cap_vec[BIDIR_BASE + CELLS_PIN*k + CELL_OUT] = out_sync[k];
        assign cap_vec[BIDIR_BASE + CELLS_PIN*k + CELL_CTL] = oe_sync[k];
        assign upd_out[k] = update_reg[BIDIR_BASE + CELLS_PIN*k + CELL_OUT];
        assign upd_ctl[k] = update_reg[BIDIR_BASE + CELLS_PIN*k + CELL_CTL];
    end

    // Capture and shift stage; bit 0 leaves first
    always_ff @(posedge tck) begin
        if (capture) begin
            shift_reg <= cap_vec;
        end else if (shift) begin
            shift_reg <= {tdi, shift_reg[CHAIN_BITS-1:1]};
        end
    end

    // Update stage; clears to all pads released
    always_ff @(posedge tck or negedge test_port_reset_n) begin
        if (!test_port_reset_n) begin
            update_reg <= '0;
        end else if (update) begin
            update_reg <= shift_reg;
        end
    end

    assign chain_tdo = shift_reg[0];

endmodule

// ==== jtag_ice_test_port.sv ====
`timescale 1ns/1ps
module jtag_ice_test_port import jtag_ice_pkg::*; (
    // Core clock and reset
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               core_ce,
    input  wire logic               chip_reset_n,
    // Mode straps
    input  wire logic               factory_test_select,
    input  wire logic               scan_vs_emulator_select,
    // Test port
    input  wire logic               tck,
    input  wire logic               test_port_reset_n,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdo_oe,
    output logic                    returned_test_clock,
    // Pads
    input  wire logic [N_BIDIR-1:0] pad_in,
    input  wire logic               boot_mode_pin,
    output logic [N_BIDIR-1:0]      pad_out,
    output logic [N_BIDIR-1:0]      pad_oe,
    // Functional pad drive from the core
    input  wire logic [N_BIDIR-1:0] core_pad_out,
    input  wire logic [N_BIDIR-1:0] core_pad_oe,
    // Processor scan chains, link clock domain
    input  wire logic [1:0]         emu_chain_tdo,
    output emu_chain_ctl_t          emu_ctl,
    // Debug unit
    input  wire logic               dbg_channel_tx_flag,
    input  wire logic               dbg_channel_rx_flag,
    input  wire logic               dbg_tx_irq_en,
    input  wire logic               dbg_rx_irq_en,
    input  wire logic               ice_access_block,
    output logic                    dbg_tx_irq,
    output logic                    dbg_rx_irq,
    output logic                    emu_sys_access_en,
    output logic [ID_LEN-1:0]       chip_id,
    // Status
    output logic                    scan_mode,
    output logic                    factory_test_active
);

    // ---------------- core clock domain ----------------
    logic sel_meta, sel_sync, fact_meta, fact_sync, crst_meta, crst_sync;
    logic tck_meta, tck_sync;
    logic chip_in_reset;
    logic mode_reg;
    logic ext_meta, ext_sync;
    logic [N_BIDIR-1:0] ob_meta, ob_sync, cb_meta, cb_sync;
    // ---------------- link clock domain ----------------
    tap_state_t state_reg, state_next;
    logic [IR_LEN-1:0]     ir_shift_reg, ir_reg;
    logic [SCAN_N_LEN-1:0] scann_shift_reg, scann_reg;
    logic [ID_LEN-1:0]     id_shift_reg;
    logic                  bypass_reg;
    logic                  mode_meta, mode_link, blk_meta, blk_link;
    logic                  extest_link_reg;
    dr_sel_t               dr_sel;
    logic                  pins_tdo, chain_out;
    logic [N_BIDIR-1:0]    upd_out, upd_ctl;
    logic                  tdo_next;

    // Strap and pin synchronisers; not reset, so a strap is seen even during reset
    always_ff @(posedge core_clk) begin
        sel_meta  <= scan_vs_emulator_select;
        sel_sync  <= sel_meta;
        fact_meta <= factory_test_select;
        fact_sync <= fact_meta;
        crst_meta <= chip_reset_n;
        crst_sync <= crst_meta;
        tck_meta  <= tck;
        tck_sync  <= tck_meta;
    end

    assign chip_in_reset = sys_rst | ~crst_sync;

    // Mode is caught only while the chip is in reset, never switched live
    always_ff @(posedge core_clk) begin
        if (chip_in_reset) begin
            mode_reg <= sel_sync;
        end
    end

    // Status outputs and the returned clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scan_mode           <= 1'h0;
            factory_test_active <= 1'h0;
            returned_test_clock <= 1'h0;
            chip_id             <= CHIP_ID_VALUE;
        end else if (core_ce) begin
            scan_mode           <= mode_reg;
            factory_test_active <= fact_sync;
            returned_test_clock <= tck_sync;
            chip_id             <= CHIP_ID_VALUE;
        end
    end

    // Debug channel activity becomes interrupt requests
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dbg_tx_irq <= 1'h0;
            dbg_rx_irq <= 1'h0;
        end else if (core_ce) begin
            dbg_tx_irq <= dbg_channel_tx_flag & dbg_tx_irq_en;
            dbg_rx_irq <= dbg_channel_rx_flag & dbg_rx_irq_en;
        end
    end

    // System access through the emulator is only granted in emulator mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            emu_sys_access_en <= 1'h0;
        end else if (core_ce) begin
            emu_sys_access_en <= ~ice_access_block & ~mode_reg;
        end
    end

    // Update cells are quasi-static during external test, so per-bit
    // two-flop resync is enough; a pin may lag its neighbours by one cycle
    always_ff @(posedge core_clk) begin
        ext_meta <= extest_link_reg;
        ext_sync <= ext_meta;
        ob_meta  <= upd_out;
        ob_sync  <= ob_meta;
        cb_meta  <= upd_ctl;
        cb_sync  <= cb_meta;
    end

    // Pad drive: boundary cells during external test, the core otherwise
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pad_out <= '0;
            pad_oe  <= '0;
        end else if (core_ce) begin
            if (ext_sync) begin
                pad_out <= ob_sync;
                pad_oe  <= cb_sync;
            end else begin
                pad_out <= core_pad_out;
                pad_oe  <= core_pad_oe;
            end
        end
    end

    // ---------------- link side ----------------

    // Mode and block levels cross into the link clock
    always_ff @(posedge tck) begin
        mode_meta <= mode_reg;
        mode_link <= mode_meta;
        blk_meta  <= ice_access_block;
        blk_link  <= blk_meta;
    end

    // Data register selection from instruction, mode and chain number
    function automatic dr_sel_t decode_dr(input logic [IR_LEN-1:0] ir, input logic scan,
                                          input logic [SCAN_N_LEN-1:0] chain, input logic blk);
        decode_dr = DR_BYPASS;
        if (scan) begin
            if (ir == OP_EXTEST || ir == OP_SAMPLE) begin
                decode_dr = DR_PINS;
            end
        end else begin
            case (ir)
                OP_IDCODE: decode_dr = DR_ID;
                OP_SCAN_N: decode_dr = blk ? DR_BYPASS : DR_SCANN;
                OP_INTEST: decode_dr = (!blk && (chain == CHAIN_A || chain == CHAIN_B)) ? DR_CHAIN : DR_BYPASS;
                default:   decode_dr = DR_BYPASS;
            endcase
        end
    endfunction

    assign dr_sel = decode_dr(ir_reg, mode_link, scann_reg, blk_link);

    // Standard state transitions under test mode select
    always_comb begin
        case (state_reg)
            TLR:     state_next = tms ? TLR    : RTI;
            RTI:     state_next = tms ? SEL_DR : RTI;
            SEL_DR:  state_next = tms ? SEL_IR : CAP_DR;
            CAP_DR:  state_next = tms ? EX1_DR : SH_DR;
            SH_DR:   state_next = tms ? EX1_DR : SH_DR;
            EX1_DR:  state_next = tms ? UPD_DR : PA_DR;
            PA_DR:   state_next = tms ? EX2_DR : PA_DR;
            EX2_DR:  state_next = tms ? UPD_DR : SH_DR;
            UPD_DR:  state_next = tms ? SEL_DR : RTI;
            SEL_IR:  state_next = tms ? TLR    : CAP_IR;
            CAP_IR:  state_next = tms ? EX1_IR : SH_IR;
            SH_IR:   state_next = tms ? EX1_IR : SH_IR;
            EX1_IR:  state_next = tms ? UPD_IR : PA_IR;
            PA_IR:   state_next = tms ? EX2_IR : PA_IR;
            EX2_IR:  state_next = tms ? UPD_IR : SH_IR;
            UPD_IR:  state_next = tms ? SEL_DR : RTI;
            default: state_next = TLR;
        endcase
    end

    always_ff @(posedge tck or negedge test_port_reset_n) begin
        if (!test_port_reset_n) begin
            state_reg <= TLR;
        end else begin
            state_reg <= state_next;
        end
    end

    // Instruction register; reset loads BYPASS, then Test-Logic-Reset picks the mode's default instruction
    always_ff @(posedge tck or negedge test_port_reset_n) begin
        if (!test_port_reset_n) begin
            ir_shift_reg <= IR_CAPTURE;
            ir_reg       <= OP_BYPASS;
        end else if (state_reg == TLR) begin
            ir_reg <= mode_link ? OP_BYPASS : OP_IDCODE;
        end else if (state_reg == CAP_IR) begin
            ir_shift_reg <= IR_CAPTURE;
        end else if (state_reg == SH_IR) begin
            ir_shift_reg <= {tdi, ir_shift_reg[IR_LEN-1:1]};
        end else if (state_reg == UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // Bypass, identification and chain number shift registers
    always_ff @(posedge tck) begin
        if (state_reg == CAP_DR) begin
            bypass_reg      <= 1'h0;
            id_shift_reg    <= EMU_ID_VALUE;
            scann_shift_reg <= scann_reg;
        end else if (state_reg == SH_DR) begin
            bypass_reg <= tdi;
            if (dr_sel == DR_ID) begin
                id_shift_reg <= {tdi, id_shift_reg[ID_LEN-1:1]};
            end
            if (dr_sel == DR_SCANN) begin
                scann_shift_reg <= {tdi, scann_shift_reg[SCAN_N_LEN-1:1]};
            end
        end
    end

    // Chain number picks which processor chain a later INTEST reaches
    always_ff @(posedge tck or negedge test_port_reset_n) begin
        if (!test_port_reset_n) begin
            scann_reg <= SCAN_N_RST;
        end else if (state_reg == UPD_DR && dr_sel == DR_SCANN) begin
            scann_reg <= scann_shift_reg;
        end
    end

    // Strobes for the processor chains, registered from the next state
    // so they stand exactly during the matching state
    always_ff @(posedge tck or negedge test_port_reset_n) begin
        if (!test_port_reset_n) begin
            emu_ctl         <= '0;
            extest_link_reg <= 1'h0;
        end else begin
            emu_ctl.select  <= (dr_sel == DR_CHAIN) ? {scann_reg == CHAIN_B, scann_reg == CHAIN_A} : 2'h0;
            emu_ctl.capture <= (dr_sel == DR_CHAIN) && (state_next == CAP_DR);
            emu_ctl.shift   <= (dr_sel == DR_CHAIN) && (state_next == SH_DR);
            emu_ctl.update  <= (dr_sel == DR_CHAIN) && (state_next == UPD_DR);
            extest_link_reg <= mode_link && (ir_reg == OP_EXTEST);
        end
    end

    pin_scan_chain u_pin_scan_chain (
        .tck               (tck),
        .test_port_reset_n (test_port_reset_n),
        .capture           (dr_sel == DR_PINS && state_reg == CAP_DR),
        .shift             (dr_sel == DR_PINS && state_reg == SH_DR),
        .update            (dr_sel == DR_PINS && state_reg == UPD_DR && ir_reg == OP_EXTEST),
        .tdi               (tdi),
        .chain_tdo         (pins_tdo),
        .pad_in            (pad_in),
        .core_pad_out      (core_pad_out),
        .core_pad_oe       (core_pad_oe),
        .boot_mode_pin     (boot_mode_pin),
        .upd_out           (upd_out),
        .upd_ctl           (upd_ctl)
    );

    assign chain_out = (scann_reg == CHAIN_B) ? emu_chain_tdo[1] : emu_chain_tdo[0];

    // Serial output source
    always_comb begin
        tdo_next = bypass_reg;
        if (state_reg == SH_IR) begin
            tdo_next = ir_shift_reg[0];
        end else begin
            case (dr_sel)
                DR_PINS:  tdo_next = pins_tdo;
                DR_ID:    tdo_next = id_shift_reg[0];
                DR_SCANN: tdo_next = scann_shift_reg[0];
                DR_CHAIN: tdo_next = chain_out;
                default:  tdo_next = bypass_reg;
            endcase
        end
    end

    // Output changes on the falling edge, as the far side samples on the rising
    always_ff @(negedge tck or negedge test_port_reset_n) begin
        if (!test_port_reset_n) begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo    <= tdo_next;
            tdo_oe <= (state_reg == SH_DR) || (state_reg == SH_IR);
        end
    end

endmodule

// ==== test_port_tester.sv ====
`timescale 1ns/1ps
module test_port_tester import jtag_ice_pkg::*; (
    // Test port toward the device
    output logic      tck,
    output logic      test_port_reset_n,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // Link clock idles low between sequences
    initial begin
        tck = 1'h0;
        test_port_reset_n = 1'h1; // Starts released so the reset call gives a real falling edge
        tms = 1'h1;
        tdi = 1'h0;
    end
    // One 80 ns period; tdo is taken at the rising edge
    task automatic step(input logic m, input logic d, output logic seen);
        tms = m;
        tdi = d;
        #40;
        tck = 1'h1;
        seen = tdo;
        #40;
        tck = 1'h0;
    endtask
    // Port reset, then park in run-test-idle
    task automatic reset_port();
        logic seen;
        test_port_reset_n = 1'h0;
        #100;
        test_port_reset_n = 1'h1;
        repeat (5) step(1'h1, 1'h0, seen);
        step(1'h0, 1'h0, seen);
    endtask
    // Capture, shift and update of IR or DR, LSB first
    task automatic shift(input bit ir, input logic din[$], output logic dout[$]);
        logic seen;
        dout = {};
        step(1'h1, 1'h0, seen);
        if (ir) step(1'h1, 1'h0, seen);
        repeat (2) step(1'h0, 1'h0, seen);
        foreach (din[i]) begin
            step(i == din.size() - 1, din[i], seen);
            dout.push_back(seen);
        end
        step(1'h1, 1'h0, seen);
        step(1'h0, 1'h0, seen);
    endtask
endmodule

// ==== jtag_ice_test_port_assertions.sv ====
`timescale 1ns/1ps
module jtag_ice_test_port_checker import jtag_ice_pkg::*; (
    // Core side
    input wire logic               core_clk,
    input wire logic               sys_rst,
    input wire logic               core_ce,
    input wire logic               scan_mode,
    input wire logic [ID_LEN-1:0]  chip_id,
    input wire logic [N_BIDIR-1:0] core_pad_out,
    input wire logic [N_BIDIR-1:0] core_pad_oe,
    input wire logic [N_BIDIR-1:0] pad_out,
    input wire logic [N_BIDIR-1:0] pad_oe,
    // Debug unit
    input wire logic               dbg_channel_tx_flag,
    input wire logic               dbg_channel_rx_flag,
    input wire logic               dbg_tx_irq_en,
    input wire logic               dbg_rx_irq_en,
    input wire logic               ice_access_block,
    input wire logic               dbg_tx_irq,
    input wire logic               dbg_rx_irq,
    input wire logic               emu_sys_access_en,
    // Link side
    input wire logic               tck,
    input wire logic               test_port_reset_n,
    input wire logic               tdo_oe,
    input wire emu_chain_ctl_t     emu_ctl
);
    logic [1:0] run_reg;
    // Edges since release; the mode may still settle in the first two
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            run_reg <= 2'h0;
        end else if (run_reg != 2'h3) begin
            run_reg <= run_reg + 2'h1;
        end
    end
    tx_irq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_ce |=> dbg_tx_irq == $past(dbg_channel_tx_flag && dbg_tx_irq_en)) else $error("tx irq wrong");
    rx_irq_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(dbg_rx_irq) |-> $past(dbg_channel_rx_flag && dbg_rx_irq_en)) else $error("rx irq unprompted");
    chip_id_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        chip_id == CHIP_ID_VALUE) else $error("chip id wrong");
    access_block_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ice_access_block && core_ce |=> !emu_sys_access_en) else $error("access not blocked");
    mode_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        run_reg == 2'h3 |-> $stable(scan_mode)) else $error("mode changed without reset");
    pad_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_ce && !scan_mode |=> pad_out == $past(core_pad_out) && pad_oe == $past(core_pad_oe))
        else $error("pads do not follow core");
    scan_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        scan_mode |-> !(emu_ctl.capture || emu_ctl.shift || emu_ctl.update)) else $error("emulator strobe in scan");
    chain_onehot_a: assert property (@(posedge tck) disable iff (!test_port_reset_n)
        emu_ctl.shift |-> $onehot(emu_ctl.select)) else $error("chain select not one-hot");
    shift_drive_a: assert property (@(posedge tck) disable iff (!test_port_reset_n)
        emu_ctl.shift |-> tdo_oe) else $error("tdo idle while shifting");
    // Main scenarios reached
    cover property (@(posedge core_clk) $rose(dbg_tx_irq));
    cover property (@(posedge tck) emu_ctl.shift);
    cover property (@(posedge core_clk) scan_mode && pad_oe != core_pad_oe);
endmodule
bind jtag_ice_test_port jtag_ice_test_port_checker chk_u (.*);

// ==== jtag_ice_test_port_test.sv ====
`timescale 1ns/1ps
module jtag_ice_test_port_test import jtag_ice_pkg::*; ;
    // Design ports
    logic core_clk, sys_rst, core_ce, chip_reset_n, factory_test_select, scan_vs_emulator_select;
    logic tck, test_port_reset_n, tms, tdi, tdo, tdo_oe, returned_test_clock, boot_mode_pin;
    logic [N_BIDIR-1:0] pad_in, pad_out, pad_oe, core_pad_out, core_pad_oe, exp_out, exp_oe;
    logic [1:0] emu_chain_tdo;
    emu_chain_ctl_t emu_ctl;
    logic dbg_channel_tx_flag, dbg_channel_rx_flag, dbg_tx_irq_en, dbg_rx_irq_en, ice_access_block;
    logic dbg_tx_irq, dbg_rx_irq, emu_sys_access_en, scan_mode, factory_test_active;
    logic [ID_LEN-1:0] chip_id;
    // Bench state
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] v, r;
    logic [2:0] exp_dbg;
    logic din[$], dout[$], exp_q[$];
    logic [3:0] ops [3] = '{OP_IDCODE, OP_SCAN_N, OP_INTEST};

    jtag_ice_test_port dut_u (.*);
    test_port_tester port_u (.*);

    // Core clock; the tester makes the link clock
    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard, well above the few thousand cycles needed
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic check(input logic [N_BIDIR-1:0] seen, input logic [N_BIDIR-1:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // 32-bit DR or 4-bit IR transfer through the tester
    task automatic xfer(input bit ir, input logic [31:0] val, output logic [31:0] res);
        logic qi[$], qo[$];
        for (int i = 0; i < (ir ? IR_LEN : 32); i++) qi.push_back(val[i]);
        port_u.shift(ir, qi, qo);
        res = '0;
        foreach (qo[i]) res[i] = qo[i];
    endtask
    function automatic logic [N_BIDIR-1:0] rand_pins();
        logic [191:0] w;
        w = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        return w[N_BIDIR-1:0];
    endfunction
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Main sequence: emulator mode first, then boundary scan
    initial begin
        {sys_rst, chip_reset_n, core_ce, boot_mode_pin} = 4'he;
        factory_test_select = 1'h0;
        {scan_vs_emulator_select, ice_access_block, emu_chain_tdo} = 4'h0;
        {dbg_channel_tx_flag, dbg_channel_rx_flag, dbg_tx_irq_en, dbg_rx_irq_en} = 4'h0;
        {pad_in, core_pad_out, core_pad_oe} = '0;
        exp_dbg = 3'h0;
        void'($urandom(32'hdd2658a7));
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'h0;
        port_u.reset_port();
        check(scan_mode, 1'h0);
        check(factory_test_active, 1'h0);
        check(chip_id, CHIP_ID_VALUE);
        xfer(1'h0, $urandom, r);
        check(r, EMU_ID_VALUE);
        xfer(1'h1, OP_BYPASS, r);
        check(r[3:0], IR_CAPTURE);
        v = $urandom;
        xfer(1'h0, v, r);
        check(r, {v[30:0], 1'h0});
        // Flags, enables, block and clock enable at random
        repeat (60) begin
            @(posedge core_clk);
            if (core_ce) exp_dbg = {dbg_channel_tx_flag & dbg_tx_irq_en, dbg_channel_rx_flag & dbg_rx_irq_en, !ice_access_block};
            v = $urandom;
            {dbg_channel_tx_flag, dbg_channel_rx_flag, dbg_tx_irq_en, dbg_rx_irq_en, ice_access_block} <= v[4:0];
            core_ce <= v[5] | v[6];
            core_pad_out <= rand_pins();
            @(negedge core_clk);
            check({dbg_tx_irq, dbg_rx_irq, emu_sys_access_en}, exp_dbg);
        end
        @(posedge core_clk);
        {core_ce, ice_access_block, emu_chain_tdo} <= 4'h9;
        xfer(1'h1, OP_SCAN_N, r);
        xfer(1'h0, {CHAIN_A, 28'h0}, r);
        xfer(1'h1, OP_INTEST, r);
        xfer(1'h0, v, r);
        check(r, 32'hffff_ffff);
        @(posedge core_clk);
        ice_access_block <= 1'h1;
        xfer(1'h1, OP_INTEST, r);
        xfer(1'h0, v, r);
        check(r, {v[30:0], 1'h0});
        // Strap change alone must not switch the port
        scan_vs_emulator_select <= 1'h1;
        repeat (20) @(posedge core_clk);
        check(scan_mode, 1'h0);
        check(returned_test_clock, tck);
        sys_rst <= 1'h1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'h0;
        port_u.reset_port();
        check(scan_mode, 1'h1);
        foreach (ops[i]) begin
            xfer(1'h1, ops[i], r);
            xfer(1'h0, v, r);
            check(r, {v[30:0], 1'h0});
        end
        @(posedge core_clk);
        pad_in <= rand_pins();
        core_pad_out <= rand_pins();
        core_pad_oe <= rand_pins();
        xfer(1'h1, OP_SAMPLE, r);
        for (int i = 0; i < CHAIN_BITS + 8; i++) din.push_back(1'($urandom));
        exp_q = {boot_mode_pin};
        for (int k = 0; k < N_BIDIR; k++) exp_q = {exp_q, pad_in[k], core_pad_out[k], core_pad_oe[k]};
        for (int i = 0; i < 8; i++) exp_q.push_back(din[i]);
        port_u.shift(1'h0, din, dout);
        foreach (exp_q[i]) check(dout[i], exp_q[i]);
        xfer(1'h1, OP_EXTEST, r);
        din = {};
        for (int i = 0; i < CHAIN_BITS; i++) din.push_back(1'($urandom));
        port_u.shift(1'h0, din, dout);
        repeat (10) @(negedge core_clk);
        for (int k = 0; k < N_BIDIR; k++) begin
            exp_out[k] = din[2 + 3 * k];
            exp_oe[k] = din[3 + 3 * k];
        end
        check(pad_out, exp_out);
        check(pad_oe, exp_oe);
        give_verdict();
    end
endmodule
